// File: design/kbsl_pkg.sv
// Package for the keyboard event serial link: constants and types.
// Assumes a single 50 MHz clock domain and no software-visible registers.
package kbsl_pkg;

  // Clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 20;

  // Serial word layout: eight data bits then one stop bit.
  localparam int WORD_BITS  = 9;
  localparam int DATA_BITS  = 8;
  localparam int KEY_BITS   = 7;
  localparam int STATE_POS  = 7;
  localparam logic STOP_VAL = 1'b1;

  // Key state values carried in the top data bit.
  localparam logic KEY_CLOSE = 1'b1;
  localparam logic KEY_OPEN  = 1'b0;

  // Default geometry and time-out.
  localparam int NUM_KEYS_DEF  = 128;
  localparam int QUEUE_DEF     = 16;
  localparam int TIMEOUT_US    = 1000;
  localparam int TIMEOUT_CYC   = TIMEOUT_US * 1000 / CLK_PERIOD_NS;
  localparam int RETRY_US      = 10;
  localparam int RETRY_CYC     = RETRY_US * 1000 / CLK_PERIOD_NS;

  // Reset values.
  localparam logic [3:0] BIT_IDX_RST = 4'h0;

  // Transmitter states.
  typedef enum logic [2:0] {
    KBSL_IDLE   = 3'b000,
    KBSL_PRES   = 3'b001,
    KBSL_WACK   = 3'b010,
    KBSL_WREL   = 3'b011,
    KBSL_BACKOF = 3'b100
  } kbsl_tx_st_t;

endpackage : kbsl_pkg

// File: design/kbsl_sync.sv
// Two-flop synchroniser for a single level from outside the clock domain.
// Assumes the input is a slow level; the first flop feeds only the second.
`timescale 1ns/100ps
`default_nettype none
module kbsl_sync
  import kbsl_pkg::*;
(
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic arst_n,
  // Level in and out
  input  wire logic d,
  output logic      q
);

  typedef struct packed {
    logic s1;
    logic s2;
  } kbsl_sync_st_t;

  kbsl_sync_st_t st;
  kbsl_sync_st_t next_st;

  // Shift the level through two stages.
  always_comb begin
    next_st    = st;
    next_st.s1 = d;
    next_st.s2 = st.s1;
  end

  // Register the state.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q = st.s2;

endmodule : kbsl_sync
`default_nettype wire

// File: design/kbsl_queue.sv
// Event queue: first-in first-out store of pending key events.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/100ps
`default_nettype none
module kbsl_queue
  import kbsl_pkg::*;
#(
  parameter int WIDTH = DATA_BITS,
  parameter int DEPTH = QUEUE_DEF
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             arst_n,
  // Write side
  input  wire logic             push,
  input  wire logic [WIDTH-1:0] wdata,
  // Read side
  input  wire logic             pop,
  output logic      [WIDTH-1:0] rdata,
  // Status
  output logic                  empty,
  output logic                  full
);

  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [AW-1:0] wptr;
    logic [AW-1:0] rptr;
    logic [AW:0]   count;
  } kbsl_q_st_t;

  kbsl_q_st_t       st;
  kbsl_q_st_t       next_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             do_push;
  logic             do_pop;

  // A push into a full queue is dropped; the caller holds off before that.
  assign do_push = push && !full;
  assign do_pop  = pop && !empty;
  assign empty   = (st.count == '0);
  assign full    = (st.count == (AW+1)'(DEPTH));
  assign rdata   = mem[st.rptr];

  // Advance pointers and occupancy.
  always_comb begin
    next_st = st;
    if (do_push) begin
      next_st.wptr = (st.wptr == AW'(DEPTH-1)) ? '0 : st.wptr + 1'b1;
    end
    if (do_pop) begin
      next_st.rptr = (st.rptr == AW'(DEPTH-1)) ? '0 : st.rptr + 1'b1;
    end
    next_st.count = st.count + (AW+1)'(do_push) - (AW+1)'(do_pop);
  end

  // Register the state.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage needs no reset; only written slots are read.
  always_ff @(posedge ref_clk) begin
    if (do_push) begin
      mem[st.wptr] <= wdata;
    end
  end

endmodule : kbsl_queue
`default_nettype wire

// File: design/kbsl_top.sv
// Keyboard scanner and serial event transmitter toward the host.
// Assumes a 50 MHz ref_clk; key levels and the acknowledge arrive asynchronously.
// How it works
// - Each event leaves as one nine-bit serial word.
// - Data bits go out least significant bit first.
// - The ninth bit is a stop bit after the data.
// - Top data bit carries key state, close or open.
// - Low seven data bits carry the key number.
// - The scanner visits every key continually to spot changes.
// - Press and release each give an event, any key count.
// - Only raw key number and state are sent, no meaning.
// - Pending events wait in a queue while the host is busy.
// - Bits appear serially on a dedicated data line.
// - A ready line tells the host a bit is available.
// - A full queue holds off scanning so no event is lost.
// - A missing acknowledge times out and the word is resent.
`timescale 1ns/100ps
`default_nettype none
module kbsl_top
  import kbsl_pkg::*;
#(
  parameter int NUM_KEYS    = NUM_KEYS_DEF,
  parameter int QUEUE_DEPTH = QUEUE_DEF,
  parameter int TIMEOUT     = TIMEOUT_CYC,
  parameter int RETRY_GAP   = RETRY_CYC
) (
  // Clock and reset
  input  wire logic                ref_clk,
  input  wire logic                arst_n,
  // Key matrix levels, high while a key is closed
  input  wire logic [NUM_KEYS-1:0] key_closed,
  // Serial link
  output logic                     ser_data,
  output logic                     ser_ready,
  input  wire logic                ser_ack,
  // Status
  output logic                     hold_off
);

  localparam int KW = $clog2(NUM_KEYS);
  // The timer also counts the retry pause, so it is sized for the longer of the two waits.
  localparam int TW = $clog2(((TIMEOUT > RETRY_GAP) ? TIMEOUT : RETRY_GAP) + 1);

  typedef struct packed {
    logic [KW-1:0]  scan_idx;
    logic [NUM_KEYS-1:0] known;
    kbsl_tx_st_t    tx;
    logic [3:0]     bit_idx;
    logic [TW-1:0]  timer;
    logic           data;
    logic           ready;
    logic           hold;
  } kbsl_st_t;

  kbsl_st_t          st;
  kbsl_st_t          next_st;
  logic [NUM_KEYS-1:0] key_s;
  logic              ack_s;
  logic              q_push;
  logic              q_pop;
  logic [DATA_BITS-1:0] q_wdata;
  logic [DATA_BITS-1:0] q_rdata;
  logic              q_empty;
  logic              q_full;
  logic              key_now;
  logic              changed;
  logic [WORD_BITS-1:0] word;

  // Every key level passes two flops before the scanner reads it.
  genvar gk;
  generate
    for (gk = 0; gk < NUM_KEYS; gk++) begin : g_key
      kbsl_sync u_sync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .d       (key_closed[gk]),
        .q       (key_s[gk])
      );
    end
  endgenerate

  kbsl_sync u_ack_sync (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .d       (ser_ack),
    .q       (ack_s)
  );

  kbsl_queue #(
    .WIDTH (DATA_BITS),
    .DEPTH (QUEUE_DEPTH)
  ) u_queue (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .push    (q_push),
    .wdata   (q_wdata),
    .pop     (q_pop),
    .rdata   (q_rdata),
    .empty   (q_empty),
    .full    (q_full)
  );

  // Scanner compares the current key with its last reported state.
  assign key_now = key_s[st.scan_idx];
  assign changed = (key_now != st.known[st.scan_idx]);
  // Event byte holds state on top and key number below; no key meaning is applied.
  assign q_wdata = {key_now ? KEY_CLOSE : KEY_OPEN, KEY_BITS'(st.scan_idx)};
  // A change is queued only when room exists; otherwise the scanner waits on it.
  assign q_push  = changed && !q_full && !st.hold;
  // Word is data LSB first then the stop bit.
  assign word    = {STOP_VAL, q_rdata};
  // The head leaves only after the stop bit is acknowledged.
  assign q_pop   = (st.tx == KBSL_WREL) && !ack_s && (st.bit_idx == 4'(WORD_BITS - 1));

  // Scanning, hold-off and the bit-level handshake.
  always_comb begin
    next_st = st;
    // Hold-off while the queue is full so no change is ever dropped.
    next_st.hold = q_full;
    // Stay on a changed key that could not be queued, else advance.
    if (!changed || q_push) begin
      next_st.scan_idx = (st.scan_idx == KW'(NUM_KEYS - 1)) ? '0 : st.scan_idx + 1'b1;
    end
    if (q_push) begin
      next_st.known[st.scan_idx] = key_now;
    end
    case (st.tx)
      KBSL_IDLE: begin
        next_st.ready   = 1'b0;
        next_st.bit_idx = BIT_IDX_RST;
        if (!q_empty && !ack_s) begin
          next_st.data = word[0];
          next_st.tx   = KBSL_PRES;
        end
      end
      KBSL_PRES: begin
        // Data was set a cycle earlier, so it is settled when ready rises.
        next_st.ready = 1'b1;
        next_st.timer = '0;
        next_st.tx    = KBSL_WACK;
      end
      KBSL_WACK: begin
        next_st.timer = st.timer + 1'b1;
        if (ack_s) begin
          next_st.ready = 1'b0;
          next_st.timer = '0;
          next_st.tx    = KBSL_WREL;
        end else if (st.timer == TW'(TIMEOUT)) begin
          // No answer: drop ready, pause and restart the word from bit 0.
          next_st.ready = 1'b0;
          next_st.timer = '0;
          next_st.tx    = KBSL_BACKOF;
        end
      end
      KBSL_WREL: begin
        // Wait for acknowledge to fall before the next bit; a stuck line times out too.
        next_st.timer = st.timer + 1'b1;
        if (!ack_s) begin
          next_st.timer = '0;
          if (st.bit_idx == 4'(WORD_BITS - 1)) begin
            next_st.tx = KBSL_IDLE;
          end else begin
            next_st.bit_idx = st.bit_idx + 4'h1;
            next_st.data    = word[st.bit_idx + 4'h1];
            next_st.tx      = KBSL_PRES;
          end
        end else if (st.timer == TW'(TIMEOUT)) begin
          next_st.timer = '0;
          next_st.tx    = KBSL_BACKOF;
        end
      end
      KBSL_BACKOF: begin
        next_st.timer = st.timer + 1'b1;
        if (st.timer >= TW'(RETRY_GAP)) begin
          next_st.timer = '0;
          next_st.tx    = KBSL_IDLE;
        end
      end
      default: begin
        next_st.tx = KBSL_IDLE;
      end
    endcase
  end

  // Register the state.
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign ser_data  = st.data;
  assign ser_ready = st.ready;
  assign hold_off  = st.hold;

  // Data may not move while ready stands.
  property p_data_stable;
    @(posedge ref_clk) disable iff (!arst_n)
      (ser_ready && $past(ser_ready)) |-> $stable(ser_data);
  endproperty
  a_data_stable: assert property (p_data_stable) else $error("data moved while ready");

  // A bit is taken when acknowledge meets a standing ready.
  sequence s_bit_taken;
    st.tx == KBSL_WACK && ack_s;
  endsequence

  // Ready falls the cycle after acknowledge is seen.
  property p_ready_drop;
    @(posedge ref_clk) disable iff (!arst_n)
      s_bit_taken |=> !ser_ready;
  endproperty
  a_ready_drop: assert property (p_ready_drop) else $error("ready held after ack");

  // First bit of a word is the head's LSB.
  property p_lsb_first;
    @(posedge ref_clk) disable iff (!arst_n)
      (st.tx == KBSL_IDLE && !q_empty && !ack_s) |=> (ser_data == $past(q_rdata[0]));
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("first bit not lsb");

  // Ninth bit on the line is the stop bit.
  property p_stop_bit;
    @(posedge ref_clk) disable iff (!arst_n)
      (ser_ready && st.bit_idx == 4'(WORD_BITS - 1)) |-> (ser_data == STOP_VAL);
  endproperty
  a_stop_bit: assert property (p_stop_bit) else $error("stop bit wrong");

  // Pops happen only after the last bit's handshake.
  property p_pop_last;
    @(posedge ref_clk) disable iff (!arst_n)
      q_pop |-> (st.bit_idx == 4'(WORD_BITS - 1) && $past(st.tx) == KBSL_WREL);
  endproperty
  a_pop_last: assert property (p_pop_last) else $error("pop before full word");

  // No push into a full queue.
  property p_no_overflow;
    @(posedge ref_clk) disable iff (!arst_n)
      q_full |-> !q_push;
  endproperty
  a_no_overflow: assert property (p_no_overflow) else $error("push while full");

  // Hold-off follows a full queue by one cycle.
  property p_hold;
    @(posedge ref_clk) disable iff (!arst_n)
      q_full |=> hold_off;
  endproperty
  a_hold: assert property (p_hold) else $error("no hold-off when full");

  // Acknowledge has fallen on a bit that is not the last of the word.
  sequence s_ack_released;
    st.tx == KBSL_WREL && !ack_s && st.bit_idx != 4'(WORD_BITS - 1);
  endsequence

  // A silent host leads to ready falling within the time-out.
  property p_timeout;
    @(posedge ref_clk) disable iff (!arst_n)
      (st.tx == KBSL_WACK && !ack_s && st.timer == TW'(TIMEOUT)) |=> (st.tx == KBSL_BACKOF && !ser_ready);
  endproperty
  a_timeout: assert property (p_timeout) else $error("no retry after time-out");

  // Queued byte carries the live key state and index.
  property p_event_byte;
    @(posedge ref_clk) disable iff (!arst_n)
      q_push |-> (q_wdata[STATE_POS] == key_now && q_wdata[KEY_BITS-1:0] == KEY_BITS'(st.scan_idx));
  endproperty
  a_event_byte: assert property (p_event_byte) else $error("event byte wrong");

  // Once acknowledge falls, the next bit is set up a cycle before ready rises again.
  property p_next_bit;
    @(posedge ref_clk) disable iff (!arst_n)
      s_ack_released |=> (st.tx == KBSL_PRES && !ser_ready && st.bit_idx == $past(st.bit_idx) + 4'h1)
        ##1 ser_ready;
  endproperty
  a_next_bit: assert property (p_next_bit) else $error("next bit not presented in order");

  // A change that finds the queue full keeps the scanner on that key, so it is not lost.
  property p_scan_stall;
    @(posedge ref_clk) disable iff (!arst_n)
      (changed && !q_push) |=> $stable(st.scan_idx);
  endproperty
  a_scan_stall: assert property (p_scan_stall) else $error("scanner left an unqueued change");

  // Ready stays low through the pause before a retry.
  property p_backoff_quiet;
    @(posedge ref_clk) disable iff (!arst_n)
      (st.tx == KBSL_BACKOF) |-> !ser_ready;
  endproperty
  a_backoff_quiet: assert property (p_backoff_quiet) else $error("ready high during retry pause");

  // Every start or restart of a word presents bit 0 of the head event.
  property p_restart;
    @(posedge ref_clk) disable iff (!arst_n)
      (st.tx == KBSL_PRES && st.bit_idx == BIT_IDX_RST) |-> (ser_data == q_rdata[0]);
  endproperty
  a_restart: assert property (p_restart) else $error("word did not start at bit 0");

  // A word leaves the queue once; the pop is followed by a return to idle.
  property p_pop_once;
    @(posedge ref_clk) disable iff (!arst_n)
      q_pop |=> (st.tx == KBSL_IDLE && !q_pop);
  endproperty
  a_pop_once: assert property (p_pop_once) else $error("event popped twice");

  // Ready only rises out of the present state, a cycle after the data was set.
  property p_ready_rise;
    @(posedge ref_clk) disable iff (!arst_n)
      $rose(ser_ready) |-> ($past(st.tx) == KBSL_PRES);
  endproperty
  a_ready_rise: assert property (p_ready_rise) else $error("ready rose without data setup");

endmodule : kbsl_top
`default_nettype wire

// File: dv/kbsl_host_model.sv
// Behavioural host side of the keyboard serial link: acknowledges bits, rebuilds words.
// Assumes one clock shared with the keyboard block; pause withholds the acknowledge of any bit not yet started.
`timescale 1ns/100ps
`default_nettype none
module kbsl_host_model (
  // Clock
  input  wire logic       ref_clk,
  // Serial link
  input  wire logic       ser_data,
  input  wire logic       ser_ready,
  output var  logic       ser_ack,
  // Control from the bench
  input  wire logic       pause,
  input  wire logic [7:0] ack_dly,
  // Rebuilt words
  output var  logic [8:0] word,
  output var  logic       word_valid,
  output var  logic       stable_err
);
  logic [8:0] shreg;
  logic       first;
  logic       rdy_q;
  int         cnt;
  int         i;

  // One four-phase handshake per bit; pausing drops a partial word since the keyboard restarts it.
  // Only a fresh rise of ready starts a bit, so a ready caught near its time-out is never taken.
  initial begin
    ser_ack = 1'b0;
    word = 9'h000;
    word_valid = 1'b0;
    stable_err = 1'b0;
    shreg = 9'h000;
    rdy_q = 1'b0;
    cnt = 0;
    forever begin
      @(posedge ref_clk);
      word_valid <= 1'b0;
      if (pause) begin
        cnt = 0;
      end else if (ser_ready === 1'b1 && rdy_q === 1'b0) begin
        first = ser_data;
        repeat (ack_dly) @(posedge ref_clk);
        if (ser_data !== first) stable_err <= 1'b1;
        shreg[cnt] = ser_data;
        ser_ack <= 1'b1;
        for (i = 0; i < 40 && ser_ready !== 1'b0; i++) @(posedge ref_clk);
        ser_ack <= 1'b0;
        cnt++;
        if (cnt == 9) begin
          word <= shreg;
          word_valid <= 1'b1;
          cnt = 0;
        end
      end
      rdy_q = ser_ready;
    end
  end
endmodule : kbsl_host_model
`default_nettype wire

// File: dv/kbsl_tb_top.sv
// Self-checking bench for the keyboard event serial link.
// Assumes the host model on the far side and small time-out and queue parameters.
`timescale 1ns/100ps
`default_nettype none
module keyboard_event_serial_link_tb_top
  import kbsl_pkg::*;
;
  localparam int NK = 128;
  localparam int QD = 4;
  localparam int TO = 50;
  localparam int RG = 4;
  logic          ref_clk;
  logic          arst_n;
  logic [NK-1:0] key_closed;
  logic          ser_data;
  logic          ser_ready;
  logic          ser_ack;
  logic          hold_off;
  logic          pause;
  logic [7:0]    ack_dly;
  logic [8:0]    word;
  logic          word_valid;
  logic          stable_err;
  logic [8:0]    got[$];
  int            error_cnt;
  int            samples_checked;

  kbsl_top #(.NUM_KEYS(NK), .QUEUE_DEPTH(QD), .TIMEOUT(TO), .RETRY_GAP(RG)) kbsl_top_i (
    .ref_clk(ref_clk), .arst_n(arst_n), .key_closed(key_closed), .ser_data(ser_data),
    .ser_ready(ser_ready), .ser_ack(ser_ack), .hold_off(hold_off));

  kbsl_host_model kbsl_host_model_i (
    .ref_clk(ref_clk), .ser_data(ser_data), .ser_ready(ser_ready), .ser_ack(ser_ack), .pause(pause),
    .ack_dly(ack_dly), .word(word), .word_valid(word_valid), .stable_err(stable_err));

  // Free-running 50 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end

  // Words collected from the host model, oldest first.
  always @(posedge ref_clk) begin
    if (word_valid === 1'b1) got.push_back(word);
  end

  task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : final_report

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : tick

  // A hang counts as a mismatch and closes the run.
  task automatic wait_words(input int n);
    int i;
    for (i = 0; i < 20000 && got.size() < n; i++) tick(1);
    if (got.size() < n) begin
      check("word count", 9'(got.size()), 9'(n));
      final_report();
    end
  endtask : wait_words

  // Two scan passes give the scanner time to see the change.
  task automatic set_key(input int k, input logic v);
    key_closed[k] <= v;
    tick(2 * NK);
  endtask : set_key

  // Stop bit sits above the event byte.
  task automatic expect_word(input logic [7:0] ev);
    logic [8:0] w;
    w = (got.size() > 0) ? got.pop_front() : 9'h000;
    check("serial word", w, {STOP_VAL, ev});
  endtask : expect_word

  // Highest key number with a slow host.
  task automatic test_slow_host();
    ack_dly <= 8'h0a;
    set_key(127, 1'b1);
    wait_words(1);
    expect_word({KEY_CLOSE, 7'h7f});
    set_key(127, 1'b0);
    wait_words(1);
    expect_word({KEY_OPEN, 7'h7f});
    ack_dly <= 8'h01;
    $display("test slow host done");
  endtask : test_slow_host

  // Withheld acknowledge must time out and the word go out again whole.
  task automatic test_timeout();
    int i;
    int n;
    pause <= 1'b1;
    set_key(5, 1'b1);
    // Wait for ready to be low and then rise, so the whole ready window is measured.
    for (i = 0; i < 200 && ser_ready !== 1'b0; i++) tick(1);
    for (i = 0; i < 200 && ser_ready !== 1'b1; i++) tick(1);
    for (n = 0; n < 200 && ser_ready !== 1'b0; n++) tick(1);
    check("ready time-out", 9'(n >= TO - 1 && n <= TO + 3), 9'h001);
    for (i = 0; i < RG + 20 && ser_ready !== 1'b1; i++) tick(1);
    check("retry ready", {8'h00, ser_ready}, 9'h001);
    pause <= 1'b0;
    wait_words(1);
    expect_word({KEY_CLOSE, 7'h05});
    set_key(5, 1'b0);
    wait_words(1);
    expect_word({KEY_OPEN, 7'h05});
    $display("test timeout done");
  endtask : test_timeout

  // More events than the queue holds while the host is stalled.
  task automatic test_holdoff();
    int k;
    pause <= 1'b1;
    for (k = 0; k < QD + 2; k++) set_key(k, 1'b1);
    check("hold off full", {8'h00, hold_off}, 9'h001);
    pause <= 1'b0;
    wait_words(QD + 2);
    for (k = 0; k < QD + 2; k++) expect_word({KEY_CLOSE, 7'(k)});
    check("hold off drained", {8'h00, hold_off}, 9'h000);
    for (k = 0; k < QD + 2; k++) set_key(k, 1'b0);
    wait_words(QD + 2);
    for (k = 0; k < QD + 2; k++) expect_word({KEY_OPEN, 7'(k)});
    $display("test hold off done");
  endtask : test_holdoff

  // Main sequence: reset, scenarios, then leftovers and stability.
  initial begin
    error_cnt = 0;
    samples_checked = 0;
    arst_n = 1'b0;
    key_closed = '0;
    pause = 1'b0;
    ack_dly = 8'h01;
    tick(5);
    arst_n <= 1'b1;
    tick(2 * NK);
    test_slow_host();
    test_timeout();
    test_holdoff();
    tick(200);
    check("extra words", 9'(got.size()), 9'h000);
    check("data stable", {8'h00, stable_err}, 9'h000);
    final_report();
  end
endmodule : keyboard_event_serial_link_tb_top
`default_nettype wire
